// *** pkg/fos_defines.vh ***
// register map, field positions, reset values and sizes for the fifo
// occupancy status block; assumes a 32-bit apb slave on pclk.
`ifndef FOS_DEFINES_VH
`define FOS_DEFINES_VH

// queue sizes
`define FOS_DEPTH          5'h10
`define FOS_LVL_W          5

// register byte offsets
`define FOS_OFF_STAT       12'h000
`define FOS_OFF_INTSTAT    12'h004
`define FOS_OFF_INTCLR     12'h008
`define FOS_OFF_INTEN      12'h00C

// status register fields
`define FOS_BIT_OVERRUN    1
`define FOS_BIT_TX_DRAINED 4
`define FOS_BIT_TX_ROOM    5
`define FOS_BIT_RX_DATA    6
`define FOS_BIT_RX_FULL    7
`define FOS_TXLVL_LSB      8
`define FOS_RXLVL_LSB      16

// reset values
`define FOS_RST_TX_DRAINED 1'h1
`define FOS_RST_TX_ROOM    1'h1
`define FOS_RST_RX_DATA    1'h0
`define FOS_RST_RX_FULL    1'h0
`define FOS_RST_OVERRUN    1'h0

// interrupt event bits
`define FOS_EV_W           4
`define FOS_EV_RX_OVF      0
`define FOS_EV_TX_OVF      1
`define FOS_EV_TX_DRAINED  2
`define FOS_EV_RX_FULL     3

`endif

// *** testbench/fos_chk.sv ***
// assertions on the fifo occupancy status block's ports;
// assumes binding into fos_top, single pclk domain.
`timescale 1ns/1ps
`include "fos_defines.vh"

module fos_chk (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  tx_push,
  input wire logic                  tx_pop,
  input wire logic                  rx_push,
  input wire logic                  rx_pop,
  input wire logic                  tx_queue_drained,
  input wire logic                  tx_queue_has_room,
  input wire logic                  rx_queue_has_data,
  input wire logic                  rx_queue_at_capacity,
  input wire logic                  rx_overrun_flag,
  input wire logic [`FOS_LVL_W-1:0] tx_level,
  input wire logic [`FOS_LVL_W-1:0] rx_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completing write of 1 to the overrun bit of the status word
  wire ovr_clr = psel && penable && pready && pwrite &&
                 paddr == 12'h000 && pwdata[1];

  tx_drained_a: assert property (tx_queue_drained == (tx_level == 0))
    else $error("tx drained flag disagrees with tx level");
  tx_room_a: assert property (tx_queue_has_room == (tx_level != 16))
    else $error("tx room flag disagrees with tx level");
  rx_data_a: assert property (rx_queue_has_data == (rx_level != 0))
    else $error("rx data flag disagrees with rx level");
  rx_full_a: assert property (rx_queue_at_capacity == (rx_level == 16))
    else $error("rx full flag disagrees with rx level");
  ovr_set_a: assert property (rx_push && !rx_pop && rx_level == 16
    |=> rx_overrun_flag) else $error("overrun flag not set");
  ovr_hold_a: assert property (rx_overrun_flag && !ovr_clr
    |=> rx_overrun_flag) else $error("overrun flag dropped early");
  ovr_cause_a: assert property ($rose(rx_overrun_flag)
    |-> $past(rx_push && rx_level == 16)) else $error("overrun no cause");
  rx_count_a: assert property (rx_push && !rx_pop && rx_level < 16
    |=> rx_level == $past(rx_level) + 1) else $error("rx level stale");
  tx_count_a: assert property (tx_pop && !tx_push && tx_level != 0
    |=> tx_level == $past(tx_level) - 1) else $error("tx level stale");

  cover property (rx_overrun_flag);
  cover property (!tx_queue_has_room);
  cover property (rx_queue_at_capacity && rx_pop);
endmodule // fos_chk

bind fos_top fos_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .tx_push, .tx_pop, .rx_push, .rx_pop,
  .tx_queue_drained, .tx_queue_has_room, .rx_queue_has_data,
  .rx_queue_at_capacity, .rx_overrun_flag, .tx_level, .rx_level);

// *** testbench/fos_far.sv ***
// processor or dma side: fills the tx queue and drains the rx queue;
// assumes fos_top's registered flags on pclk.
`timescale 1ns/1ps

module fos_far (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fill,
  input  wire logic drain,
  input  wire logic tx_queue_has_room,
  input  wire logic rx_queue_has_data,
  output logic      tx_push,
  output logic      rx_pop
);
  // every other cycle, so each decision sees the flag after the last move
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_push <= 1'b0;
      rx_pop  <= 1'b0;
    end else begin
      tx_push <= fill && tx_queue_has_room && !tx_push;
      rx_pop  <= drain && rx_queue_has_data && !rx_pop;
    end
  end
endmodule // fos_far

// *** testbench/fos_top_tb.sv ***
// self-checking bench for fos_top over apb with a far-side model;
// assumes fos_chk is bound in by its own file.
`timescale 1ns/1ps
`include "fos_defines.vh"

module fos_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, tx_push, tx_pop = 0, rx_push = 0, rx_pop;
  logic fill = 0, drain = 0, irq, drn, room, hasd, full, ovr;
  logic [`FOS_LVL_W-1:0] txl, rxl;
  int mismatches = 0, comparisons = 0, cycles = 0, n;

  fos_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_push, .tx_pop, .rx_push,
    .rx_pop, .tx_queue_drained(drn), .tx_queue_has_room(room),
    .rx_queue_has_data(hasd), .rx_queue_at_capacity(full),
    .rx_overrun_flag(ovr), .tx_level(txl), .rx_level(rxl), .irq);
  fos_far far_u (.pclk, .presetn, .fill, .drain,
    .tx_queue_has_room(room), .rx_queue_has_data(hasd), .tx_push, .rx_pop);

  initial forever #5 pclk = ~pclk;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin mismatches++; wrap_up; end
  end

  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer; pready and read data taken at the rising edge
  // itself, where the flops still show what stood through the cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata; er = pslverr;
    // released only after the completing edge
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0); cmp(rd, e);
  endtask
  task pulse(input bit rx, input int k);
    repeat (k) begin
      @(posedge pclk); if (rx) rx_push <= 1'b1; else tx_pop <= 1'b1;
      @(posedge pclk); rx_push <= 1'b0; tx_pop <= 1'b0;
    end
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h00000030);
    fill <= 1'b1;
    n = 0;
    while (room !== 1'b0 && n < 100) begin @(negedge pclk); n++; end
    fill <= 1'b0;
    rdc(12'h000, 32'h00001000);
    pulse(0, 16);
    @(negedge pclk); cmp({31'h0, drn}, 32'h1);
    pulse(1, 16);
    rdc(12'h000, 32'h001000F0);
    cmp({21'h0, txl, rxl, full}, 32'h00000021);
    cmp({31'h0, irq}, 32'h0);
    pulse(1, 1);
    rdc(12'h000, 32'h001000F2);
    rdc(12'h004, 32'h0000000D);
    apb(1'b1, 12'h00C, 32'h1);
    @(negedge pclk); cmp({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    @(negedge pclk); cmp({31'h0, irq}, 32'h0);
    rdc(12'h00C, 32'h00000001);
    apb(1'b1, 12'h000, 32'h2);
    rdc(12'h000, 32'h001000F0);
    drain <= 1'b1;
    n = 0;
    while (hasd !== 1'b0 && n < 100) begin @(negedge pclk); n++; end
    drain <= 1'b0;
    rdc(12'h000, 32'h00000030);
    rdc(12'h010, 32'h0); cmp({31'h0, er}, 32'h1);
    wrap_up;
  end
endmodule // fos_top_tb

// *** verilog/fos_irq.v ***
// sticky interrupt status, enable mask and level interrupt output;
// assumes write strobes are one-cycle pulses at apb completion.
`timescale 1ns/1ps
`include "fos_defines.vh"

module fos_irq (
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire [`FOS_EV_W-1:0]  event_in,
  input  wire                  clr_wr,
  input  wire                  en_wr,
  input  wire [`FOS_EV_W-1:0]  wdata,
  output reg  [`FOS_EV_W-1:0]  status_q,
  output reg  [`FOS_EV_W-1:0]  enable_q,
  output reg                   irq_q
);

  wire [`FOS_EV_W-1:0] clr_mask;
  wire [`FOS_EV_W-1:0] status_d;
  wire [`FOS_EV_W-1:0] enable_d;

  // an event in the clearing cycle survives the clear
  assign clr_mask = clr_wr ? wdata : 4'h0;
  assign status_d = event_in | (status_q & ~clr_mask);
  assign enable_d = en_wr ? wdata : enable_q;

  // irq is registered from next values so it tracks status without lag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 4'h0;
      enable_q <= 4'h0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q    <= |(status_d & enable_d);
    end
  end

endmodule // fos_irq

// *** verilog/fos_level.v ***
// entry counter for one queue, with overflow and underflow pulses;
// assumes push and pop are one-cycle strobes on pclk.
`timescale 1ns/1ps
`include "fos_defines.vh"

module fos_level (
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire                  push,
  input  wire                  pop,
  output wire [`FOS_LVL_W-1:0] level_d,
  output reg  [`FOS_LVL_W-1:0] level_q,
  output wire                  overflow,
  output wire                  underflow
);

  wire                  full_now;
  wire                  empty_now;
  wire                  do_push;
  wire                  do_pop;
  reg  [`FOS_LVL_W-1:0] nxt;

  assign full_now  = (level_q == `FOS_DEPTH);
  assign empty_now = (level_q == {`FOS_LVL_W{1'b0}});
  // a pop in the same cycle frees the slot a full push needs
  assign do_pop    = pop & ~empty_now;
  assign do_push   = push & (~full_now | do_pop);
  assign overflow  = push & full_now & ~do_pop;
  assign underflow = pop & empty_now;

  // next count; the word that overflows is dropped
  always @* begin
    nxt = level_q;
    if (do_push & ~do_pop) begin
      nxt = level_q + 5'h01;
    end else if (do_pop & ~do_push) begin
      nxt = level_q - 5'h01;
    end
  end
  assign level_d = nxt;

  // count register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 5'h00;
    end else begin
      level_q <= nxt;
    end
  end

endmodule // fos_level

// *** verilog/fos_top.v ***
// fifo occupancy status block: queue counters, four occupancy flags,
// rx overrun flag, interrupt logic and an apb register slave.
// assumes the queues' push and pop strobes are one cycle on pclk.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fos_defines.vh"

module fos_top (
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [11:0]           paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  input  wire                  tx_push,
  input  wire                  tx_pop,
  input  wire                  rx_push,
  input  wire                  rx_pop,
  output reg                   tx_queue_drained,
  output reg                   tx_queue_has_room,
  output reg                   rx_queue_has_data,
  output reg                   rx_queue_at_capacity,
  output reg                   rx_overrun_flag,
  output wire [`FOS_LVL_W-1:0] tx_level,
  output wire [`FOS_LVL_W-1:0] rx_level,
  output wire                  irq
);

  // occupancy decode, used for both queues
  function is_empty;
    input [`FOS_LVL_W-1:0] lvl;
    begin
      is_empty = (lvl == 5'h00);
    end
  endfunction

  function is_full;
    input [`FOS_LVL_W-1:0] lvl;
    begin
      is_full = (lvl == `FOS_DEPTH);
    end
  endfunction

  wire [`FOS_LVL_W-1:0] tx_lvl_d;
  wire [`FOS_LVL_W-1:0] rx_lvl_d;
  wire                  tx_ovf;
  wire                  rx_ovf;
  wire [`FOS_EV_W-1:0]  events;
  wire [`FOS_EV_W-1:0]  int_status;
  wire [`FOS_EV_W-1:0]  int_enable;
  wire                  access;
  wire                  fire;
  wire                  wr_fire;
  wire                  wr_stat;
  wire                  wr_clr;
  wire                  wr_en;
  wire                  overrun_d;
  reg  [31:0]           rd_mux;
  reg                   addr_ok;

  // transmit queue counter
  fos_level u_tx_level (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (tx_push),
    .pop       (tx_pop),
    .level_d   (tx_lvl_d),
    .level_q   (tx_level),
    .overflow  (tx_ovf),
    .underflow ()
  );

  // receive queue counter
  fos_level u_rx_level (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (rx_push),
    .pop       (rx_pop),
    .level_d   (rx_lvl_d),
    .level_q   (rx_level),
    .overflow  (rx_ovf),
    .underflow ()
  );

  // flags load from the next count so they move with the count itself;
  // the drained flag ignores the engine, it may still be shifting a word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_queue_drained     <= `FOS_RST_TX_DRAINED;
      tx_queue_has_room    <= `FOS_RST_TX_ROOM;
      rx_queue_has_data    <= `FOS_RST_RX_DATA;
      rx_queue_at_capacity <= `FOS_RST_RX_FULL;
    end else begin
      tx_queue_drained     <= is_empty(tx_lvl_d);
      tx_queue_has_room    <= ~is_full(tx_lvl_d);
      rx_queue_has_data    <= ~is_empty(rx_lvl_d);
      rx_queue_at_capacity <= is_full(rx_lvl_d);
    end
  end

  // apb: one wait state, so every answer comes from flip-flops
  assign access  = psel & penable;
  assign fire    = access & pready;
  assign wr_fire = fire & pwrite & addr_ok;
  assign wr_stat = wr_fire & (paddr == `FOS_OFF_STAT);
  assign wr_clr  = wr_fire & (paddr == `FOS_OFF_INTCLR);
  assign wr_en   = wr_fire & (paddr == `FOS_OFF_INTEN);

  // overrun sets on rx overflow; a set in the clearing cycle wins
  assign overrun_d = rx_ovf |
                     (rx_overrun_flag &
                      ~(wr_stat & pwdata[`FOS_BIT_OVERRUN]));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overrun_flag <= `FOS_RST_OVERRUN;
    end else begin
      rx_overrun_flag <= overrun_d;
    end
  end

  // interrupt events; edges taken from the next count against the flag
  assign events[`FOS_EV_RX_OVF]     = rx_ovf;
  assign events[`FOS_EV_TX_OVF]     = tx_ovf;
  assign events[`FOS_EV_TX_DRAINED] = is_empty(tx_lvl_d) &
                                      ~tx_queue_drained;
  assign events[`FOS_EV_RX_FULL]    = is_full(rx_lvl_d) &
                                      ~rx_queue_at_capacity;

  fos_irq u_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (events),
    .clr_wr   (wr_clr),
    .en_wr    (wr_en),
    .wdata    (pwdata[`FOS_EV_W-1:0]),
    .status_q (int_status),
    .enable_q (int_enable),
    .irq_q    (irq)
  );

  // read mux and address check; the clear register reads as zero
  always @* begin
    rd_mux  = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `FOS_OFF_STAT: begin
        rd_mux[`FOS_BIT_OVERRUN]    = rx_overrun_flag;
        rd_mux[`FOS_BIT_TX_DRAINED] = tx_queue_drained;
        rd_mux[`FOS_BIT_TX_ROOM]    = tx_queue_has_room;
        rd_mux[`FOS_BIT_RX_DATA]    = rx_queue_has_data;
        rd_mux[`FOS_BIT_RX_FULL]    = rx_queue_at_capacity;
        rd_mux[`FOS_TXLVL_LSB+`FOS_LVL_W-1:`FOS_TXLVL_LSB] = tx_level;
        rd_mux[`FOS_RXLVL_LSB+`FOS_LVL_W-1:`FOS_RXLVL_LSB] = rx_level;
      end
      `FOS_OFF_INTSTAT: begin
        rd_mux[`FOS_EV_W-1:0] = int_status;
      end
      `FOS_OFF_INTCLR: begin
        rd_mux = 32'h00000000;
      end
      `FOS_OFF_INTEN: begin
        rd_mux[`FOS_EV_W-1:0] = int_enable;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // pready rises at the end of the first access cycle, falls after completion;
  // writes to the read-only interrupt status word are accepted and leave it alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access & ~pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~addr_ok;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

endmodule // fos_top
